// ===== core/wsc_pkg.sv
// wake source control: constants, register map, field layout, reset values
// assumes one 250 MHz clock and spi pins sampled as synchronous inputs
package wsc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // register addresses
  localparam logic [6:0] ADDR_INT_WAKE = 7'h06;
  localparam logic [6:0] ADDR_EXT_WAKE = 7'h07;
  localparam logic [6:0] ADDR_PULL     = 7'h08;
  localparam logic [6:0] ADDR_SPEED    = 7'h0B;

  ////////////////////////////////////////////////////////////////////////////
  // field positions
  localparam int INT_TIMER_BIT   = 6;
  localparam int INT_WDOG_BIT    = 2;
  localparam int EXT_GLOBAL_BIT  = 7;
  localparam int EXT_SENSE_BIT   = 5;
  localparam int EXT_WAKE_EN_BIT = 0;
  localparam int PULL_GPIO_LSB   = 6;
  localparam int PULL_WAKE_LSB   = 0;
  localparam int SPEED_FAST_BIT  = 4;
  localparam int STAT_FAIL_BIT   = 7;

  ////////////////////////////////////////////////////////////////////////////
  // writable bit masks
  localparam logic [7:0] INT_WR_MASK   = 8'h44;
  localparam logic [7:0] EXT_WR_MASK   = 8'hA1;
  localparam logic [7:0] PULL_WR_MASK  = 8'hC3;
  localparam logic [7:0] SPEED_WR_MASK = 8'h10;

  // power-on and soft reset values
  localparam logic [7:0] INT_RST   = 8'h00;
  localparam logic [7:0] EXT_RST   = 8'h01;
  localparam logic [7:0] PULL_RST  = 8'h00;
  localparam logic [7:0] SPEED_RST = 8'h00;

  // bits kept across restart
  localparam logic [7:0] INT_RESTART_KEEP   = 8'h40;
  localparam logic [7:0] EXT_RESTART_KEEP   = 8'hA1;
  localparam logic [7:0] PULL_RESTART_KEEP  = 8'hC3;
  localparam logic [7:0] SPEED_RESTART_KEEP = 8'h10;

  // fail-safe overwrite of external wake
  localparam logic [7:0] EXT_FAILSAFE_KEEP = 8'hA0;
  localparam logic [7:0] EXT_FAILSAFE_SET  = 8'h01;

  ////////////////////////////////////////////////////////////////////////////
  // pull encodings
  localparam logic [1:0] PULL_NONE = 2'h0;
  localparam logic [1:0] PULL_DOWN = 2'h1;
  localparam logic [1:0] PULL_UP   = 2'h2;
  localparam logic [1:0] PULL_AUTO = 2'h3;

  ////////////////////////////////////////////////////////////////////////////
  // spi frame
  localparam logic [4:0] FRAME_BITS = 5'h10;
  localparam logic [4:0] ADDR_BITS  = 5'h08;
  localparam int         WRITE_BIT  = 7;

  typedef enum logic [0:0] {SPI_IDLE, SPI_SHIFT} wsc_spi_state_e;

endpackage

// ===== core/wsc_spi_if.sv
// wake source control: carrier between spi frame engine and register bank
// assumes both ends run on ref_clk
interface wsc_spi_if;
  logic [6:0] addr;
  logic [7:0] wdata;
  logic       wr_pulse;
  logic       frame_err;
  logic [7:0] rdata;
  logic [7:0] status;

  modport engine (output addr, output wdata, output wr_pulse, output frame_err,
                  input rdata, input status);
  modport bank   (input addr, input wdata, input wr_pulse, input frame_err,
                  output rdata, output status);
endinterface

// ===== core/wsc_spi_slave.sv
// wake source control: spi frame engine, 16 bit frames, lsb first
// assumes sclk idles low, data sampled on rising and shifted on falling edge
module wsc_spi_slave
  import wsc_pkg::*;
(
  input  wire logic  ref_clk,
  input  wire logic  sys_rst,
  input  wire logic  spi_csn_n,
  input  wire logic  spi_sclk,
  input  wire logic  spi_sdi,
  output logic       spi_sdo,
  output logic       spi_sdo_oe,
  wsc_spi_if.engine  bus
);

  typedef struct packed {
    wsc_spi_state_e st;
    logic           sclk_q;
    logic [4:0]     cnt;
    logic [7:0]     hdr;
    logic [7:0]     dat;
    logic [7:0]     tx;
    logic           sdo;
    logic           oe;
    logic           wr;
    logic           err;
  } wsc_spi_s;

  localparam wsc_spi_s SPI_RST_S = '{SPI_IDLE, 1'b0, 5'h00, 8'h00, 8'h00, 8'h00, 1'b0, 1'b0, 1'b0, 1'b0};

  wsc_spi_s s;
  wsc_spi_s next_s;

  ////////////////////////////////////////////////////////////////////////////
  // frame sequencing
  always_comb
  begin
    next_s        = s;
    next_s.sclk_q = spi_sclk;
    next_s.wr     = 1'b0;
    next_s.err    = 1'b0;
    unique case (s.st)
      SPI_IDLE:
      begin
        if (!spi_csn_n)
        begin
          next_s.st  = SPI_SHIFT;
          next_s.cnt = 5'h00;
          next_s.tx  = bus.status;
          next_s.sdo = bus.status[0];
          next_s.oe  = 1'b1;
        end
      end
      SPI_SHIFT:
      begin
        if (spi_csn_n)
        begin
          next_s.st = SPI_IDLE;
          next_s.oe = 1'b0;
          if (s.cnt == FRAME_BITS)
            next_s.wr = s.hdr[WRITE_BIT];
          else
            next_s.err = 1'b1;
        end
        else if (spi_sclk && !s.sclk_q)
        begin
          if (s.cnt < ADDR_BITS)
            next_s.hdr = {spi_sdi, s.hdr[7:1]};
          else
            next_s.dat = {spi_sdi, s.dat[7:1]};
          if (s.cnt != FRAME_BITS)
            next_s.cnt = s.cnt + 5'h01;
        end
        else if (!spi_sclk && s.sclk_q)
        begin
          if (s.cnt == ADDR_BITS)
          begin
            next_s.tx  = bus.rdata;
            next_s.sdo = bus.rdata[0];
          end
          else
          begin
            next_s.tx  = {1'b0, s.tx[7:1]};
            next_s.sdo = s.tx[1];
          end
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
      s <= SPI_RST_S;
    else
      s <= next_s;
  end

  assign bus.addr      = (s.cnt < ADDR_BITS) ? s.hdr[7:1] : s.hdr[6:0];
  assign bus.wdata     = s.dat;
  assign bus.wr_pulse  = s.wr;
  assign bus.frame_err = s.err;
  assign spi_sdo       = s.sdo;
  assign spi_sdo_oe    = s.oe;

endmodule // wsc_spi_slave

// ===== core/wsc_level_track.sv
// wake source control: pin level status bit with hold-clear
// assumes the pin level arrives synchronous to ref_clk
module wsc_level_track
  import wsc_pkg::*;
#(
  parameter int W = 1
)
(
  input  wire logic          ref_clk,
  input  wire logic          sys_rst,
  input  wire logic [W-1:0]  level_in,
  input  wire logic          hold_clear,
  output logic      [W-1:0]  level_out
);

  typedef struct packed {
    logic [W-1:0] lvl;
  } wsc_lvl_s;

  wsc_lvl_s s;
  wsc_lvl_s next_s;

  always_comb
  begin
    next_s     = s;
    next_s.lvl = hold_clear ? '0 : level_in;
  end

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
      s <= '0;
    else
      s <= next_s;
  end

  assign level_out = s.lvl;

endmodule // wsc_level_track

// ===== core/wsc_wake_regs.sv
// wake source control: register bank and derived wake controls
// assumes mode and reset-class events arrive as ref_clk pulses from the mode controller
module wsc_wake_regs
  import wsc_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        sys_rst,
  input  wire logic        soft_rst,
  input  wire logic        restart_rst,
  input  wire logic        failsafe_entry,
  input  wire logic        stop_to_normal,
  input  wire logic        mode_normal,
  input  wire logic        fail_output,
  input  wire logic        gpio_is_wake,
  input  wire logic        wake_pin,
  input  wire logic        general_io_in,
  input  wire logic        wake_event,
  input  wire logic        status_event,
  input  wire logic        spi_fail_clr,
  input  wire logic        spi_csn_n,
  input  wire logic        spi_sclk,
  input  wire logic        spi_sdi,
  output logic             spi_sdo,
  output logic             spi_sdo_oe,
  output logic             irq_out_n,
  output logic             spi_fail,
  output logic             timer_wake_enable,
  output logic             wdog_stop_disable_b1,
  output logic             wake_pin_sense_sel,
  output logic             wake_pin_enable,
  output logic             meas_enable,
  output logic             gpio_cfg_ignore,
  output logic             wake_pin_level,
  output logic             general_io_level,
  output logic [1:0]       wake_pull_sel,
  output logic [1:0]       general_io_wake_pull_sel,
  output logic             fast_mode
);

  ////////////////////////////////////////////////////////////////////////////
  // state
  typedef struct packed {
    logic [7:0] int_wake;
    logic [7:0] ext_wake;
    logic [7:0] pull;
    logic [7:0] speed;
    logic       fail;
    logic       irq_n;
    logic       timer_en;
    logic       wdog_dis;
    logic       sense;
    logic       pin_en;
    logic       meas;
    logic       ign;
    logic [1:0] pin_pull;
    logic [1:0] gpio_pull;
    logic       fast;
  } wsc_regs_s;

  localparam wsc_regs_s REGS_RST_S = '{
    int_wake:  INT_RST,
    ext_wake:  EXT_RST,
    pull:      PULL_RST,
    speed:     SPEED_RST,
    fail:      1'b0,
    irq_n:     1'b1,
    timer_en:  1'b0,
    wdog_dis:  1'b0,
    sense:     1'b0,
    pin_en:    1'b1,
    meas:      1'b0,
    ign:       1'b0,
    pin_pull:  PULL_NONE,
    gpio_pull: PULL_NONE,
    fast:      1'b0
  };

  wsc_regs_s s;
  wsc_regs_s next_s;
  logic      reject;
  wsc_spi_if bus ();

  ////////////////////////////////////////////////////////////////////////////
  // spi frame engine
  wsc_spi_slave u_spi (
    .ref_clk    (ref_clk),
    .sys_rst    (sys_rst),
    .spi_csn_n  (spi_csn_n),
    .spi_sclk   (spi_sclk),
    .spi_sdi    (spi_sdi),
    .spi_sdo    (spi_sdo),
    .spi_sdo_oe (spi_sdo_oe),
    .bus        (bus.engine)
  );

  ////////////////////////////////////////////////////////////////////////////
  // level status bits
  wsc_level_track #(.W(1)) u_wake_lvl (
    .ref_clk    (ref_clk),
    .sys_rst    (sys_rst),
    .level_in   (wake_pin),
    .hold_clear (s.sense),
    .level_out  (wake_pin_level)
  );

  wsc_level_track #(.W(1)) u_general_io_level (
    .ref_clk    (ref_clk),
    .sys_rst    (sys_rst),
    .level_in   (general_io_in),
    .hold_clear (s.sense),
    .level_out  (general_io_level)
  );

  ////////////////////////////////////////////////////////////////////////////
  // read mux and status byte
  always_comb
  begin
    unique case (bus.addr)
      ADDR_INT_WAKE: bus.rdata = s.int_wake & INT_WR_MASK;
      ADDR_EXT_WAKE: bus.rdata = s.ext_wake & EXT_WR_MASK;
      ADDR_PULL:     bus.rdata = s.pull & PULL_WR_MASK;
      ADDR_SPEED:    bus.rdata = s.speed & SPEED_WR_MASK;
      default:       bus.rdata = 8'h00;
    endcase
  end

  always_comb
  begin
    bus.status                = 8'h00;
    bus.status[STAT_FAIL_BIT] = s.fail;
  end

  assign reject = bus.wr_pulse && (bus.addr == ADDR_EXT_WAKE)
                  && bus.wdata[EXT_SENSE_BIT] && fail_output;

  ////////////////////////////////////////////////////////////////////////////
  // register update
  always_comb
  begin
    next_s = s;
    if (soft_rst)
    begin
      next_s.int_wake = INT_RST;
      next_s.ext_wake = EXT_RST;
      next_s.pull     = PULL_RST;
      next_s.speed    = SPEED_RST;
    end
    else if (restart_rst)
    begin
      next_s.int_wake = s.int_wake & INT_RESTART_KEEP;
      next_s.ext_wake = s.ext_wake & EXT_RESTART_KEEP;
      next_s.pull     = s.pull & PULL_RESTART_KEEP;
      next_s.speed    = s.speed & SPEED_RESTART_KEEP;
    end
    else
    begin
      if (failsafe_entry)
      begin
        // sensing selected: left as is, pin stays no wake source
        if (!s.ext_wake[EXT_SENSE_BIT])
          next_s.ext_wake = (s.ext_wake & EXT_FAILSAFE_KEEP) | EXT_FAILSAFE_SET;
      end
      else if (bus.wr_pulse && !reject)
      begin
        unique case (bus.addr)
          ADDR_INT_WAKE: next_s.int_wake = bus.wdata & INT_WR_MASK;
          ADDR_EXT_WAKE: next_s.ext_wake = bus.wdata & EXT_WR_MASK;
          ADDR_PULL:     next_s.pull     = bus.wdata & PULL_WR_MASK;
          ADDR_SPEED:    next_s.speed    = bus.wdata & SPEED_WR_MASK;
          default:       next_s.speed    = s.speed;
        endcase
      end
      if (stop_to_normal)
        next_s.int_wake[INT_WDOG_BIT] = 1'b0;
    end

    // spi failure flag, set wins over clear
    if (reject || bus.frame_err)
      next_s.fail = 1'b1;
    else if (spi_fail_clr)
      next_s.fail = 1'b0;

    // derived outputs, registered
    next_s.timer_en = next_s.int_wake[INT_TIMER_BIT];
    next_s.wdog_dis = next_s.int_wake[INT_WDOG_BIT];
    next_s.sense    = next_s.ext_wake[EXT_SENSE_BIT];
    next_s.pin_en   = next_s.ext_wake[EXT_WAKE_EN_BIT]
                      && !next_s.ext_wake[EXT_SENSE_BIT];
    next_s.meas     = next_s.ext_wake[EXT_SENSE_BIT] && mode_normal;
    next_s.ign      = next_s.ext_wake[EXT_SENSE_BIT] && !fail_output;
    next_s.pin_pull = next_s.pull[PULL_WAKE_LSB +: 2];
    if (gpio_is_wake && !next_s.ign)
      next_s.gpio_pull = next_s.pull[PULL_GPIO_LSB +: 2];
    else
      next_s.gpio_pull = PULL_NONE;
    next_s.fast     = next_s.speed[SPEED_FAST_BIT];
    next_s.irq_n    = !(wake_event
                        || (s.ext_wake[EXT_GLOBAL_BIT] && status_event));
  end

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
      s <= REGS_RST_S;
    else
      s <= next_s;
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  assign irq_out_n                = s.irq_n;
  assign spi_fail                 = s.fail;
  assign timer_wake_enable        = s.timer_en;
  assign wdog_stop_disable_b1     = s.wdog_dis;
  assign wake_pin_sense_sel       = s.sense;
  assign wake_pin_enable          = s.pin_en;
  assign meas_enable              = s.meas;
  assign gpio_cfg_ignore          = s.ign;
  assign wake_pull_sel            = s.pin_pull;
  assign general_io_wake_pull_sel = s.gpio_pull;
  assign fast_mode                = s.fast;

endmodule // wsc_wake_regs

// ===== test/wsc_asserts.sv
// wake source control: port assertions
// assumes binding onto wsc_wake_regs, one clock
module wsc_asserts
(
  input wire logic       ref_clk,
  input wire logic       sys_rst,
  input wire logic       stop_to_normal,
  input wire logic       mode_normal,
  input wire logic       fail_output,
  input wire logic       gpio_is_wake,
  input wire logic       wake_event,
  input wire logic       spi_fail_clr,
  input wire logic       irq_out_n,
  input wire logic       spi_fail,
  input wire logic       wdog_stop_disable_b1,
  input wire logic       wake_pin_sense_sel,
  input wire logic       wake_pin_enable,
  input wire logic       meas_enable,
  input wire logic       gpio_cfg_ignore,
  input wire logic       wake_pin_level,
  input wire logic       general_io_level,
  input wire logic [1:0] general_io_wake_pull_sel
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (sys_rst);

  wdog_clear_a: assert property (stop_to_normal |=> !wdog_stop_disable_b1)
    else $error("watchdog bit kept");
  pin_enable_a: assert property (wake_pin_enable |-> !wake_pin_sense_sel)
    else $error("pin enabled while sensing");
  meas_on_a: assert property (meas_enable == (wake_pin_sense_sel && $past(mode_normal)))
    else $error("measurement enable wrong");
  cfg_ignore_a: assert property (gpio_cfg_ignore == (wake_pin_sense_sel && !$past(fail_output)))
    else $error("ignore flag wrong");
  level_hold_a: assert property (wake_pin_sense_sel && $past(wake_pin_sense_sel)
    |-> !wake_pin_level && !general_io_level)
    else $error("level not held clear");
  irq_wake_a: assert property (wake_event |=> !irq_out_n)
    else $error("no interrupt on wake");
  fail_sticky_a: assert property (spi_fail && !spi_fail_clr |=> spi_fail)
    else $error("failure flag lost");
  gpio_pull_a: assert property (general_io_wake_pull_sel != 2'h0
    |-> $past(gpio_is_wake) && !gpio_cfg_ignore)
    else $error("gpio pull applied");
endmodule // wsc_asserts

bind wsc_wake_regs wsc_asserts chk (.ref_clk, .sys_rst, .stop_to_normal, .mode_normal, .fail_output,
  .gpio_is_wake, .wake_event, .spi_fail_clr, .irq_out_n, .spi_fail, .wdog_stop_disable_b1,
  .wake_pin_sense_sel, .wake_pin_enable, .meas_enable, .gpio_cfg_ignore, .wake_pin_level,
  .general_io_level, .general_io_wake_pull_sel);

// ===== test/wsc_host.sv
// wake source control: host spi master model
// assumes sdo settled while sclk high; sclk stands low between frames
module wsc_host
(
  input  wire logic ref_clk,
  input  wire logic spi_sdo,
  output logic      spi_csn_n,
  output logic      spi_sclk,
  output logic      spi_sdi
);
  timeunit 1ns;
  timeprecision 100ps;

  initial
  begin
    spi_csn_n = 1'b1;
    spi_sclk = 1'b0;
    spi_sdi = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  // lsb first frame, sdo taken at end of high phase
  task automatic xfer(input logic [15:0] tx, input int nbits, output logic [15:0] rx);
    rx = 16'h0000;
    spi_csn_n = 1'b0;
    for (int i = 0; i < nbits; i++)
    begin
      tick(2);
      spi_sdi = tx[i];
      tick(2);
      spi_sclk = 1'b1;
      tick(2);
      rx[i] = spi_sdo;
      spi_sclk = 1'b0;
    end
    tick(2);
    spi_sdi = ~spi_sdi;
    spi_csn_n = 1'b1;
    tick(4);
  endtask
endmodule // wsc_host

// ===== test/wsc_wake_regs_bench.sv
// wake source control: self-checking bench
// assumes wsc_host drives the spi pins, events are one-cycle pulses
module wsc_wake_regs_bench
  import wsc_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  logic       ref_clk, sys_rst, mode_normal, fail_output, gpio_is_wake, wake_pin, general_io_in;
  logic [6:0] ev;
  logic       spi_csn_n, spi_sclk, spi_sdi, spi_sdo, spi_sdo_oe, irq_out_n, spi_fail;
  logic       timer_wake_enable, wdog_stop_disable_b1, wake_pin_sense_sel, wake_pin_enable;
  logic       meas_enable, gpio_cfg_ignore, wake_pin_level, general_io_level, fast_mode;
  logic [1:0] wake_pull_sel, general_io_wake_pull_sel;
  int         num_errors = 0;
  int         cmp_count = 0;

  // ev: soft, restart, failsafe, stop, wake, status, fail clear
  wsc_wake_regs uut (.ref_clk, .sys_rst, .soft_rst(ev[0]), .restart_rst(ev[1]), .failsafe_entry(ev[2]),
    .stop_to_normal(ev[3]), .mode_normal, .fail_output, .gpio_is_wake, .wake_pin, .general_io_in,
    .wake_event(ev[4]), .status_event(ev[5]), .spi_fail_clr(ev[6]), .spi_csn_n, .spi_sclk, .spi_sdi,
    .spi_sdo, .spi_sdo_oe, .irq_out_n, .spi_fail, .timer_wake_enable, .wdog_stop_disable_b1,
    .wake_pin_sense_sel, .wake_pin_enable, .meas_enable, .gpio_cfg_ignore, .wake_pin_level,
    .general_io_level, .wake_pull_sel, .general_io_wake_pull_sel, .fast_mode);
  wsc_host host (.ref_clk, .spi_sdo, .spi_csn_n, .spi_sclk, .spi_sdi);

  initial ref_clk = 1'b0;
  always #2 ref_clk = ~ref_clk;

  ////////////////////////////////////////////////////////////////////////////
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic pulse(input int k);
    ev[k] = 1'b1;
    tick(1);
    ev[k] = 1'b0;
  endtask

  task automatic wr(input logic [6:0] a, input logic [7:0] d, input int n = 16);
    logic [15:0] rx;
    host.xfer({d, 1'b1, a}, n, rx);
  endtask

  task automatic rd_chk(input logic [6:0] a, input logic [7:0] exp);
    logic [15:0] rx;
    host.xfer({8'h00, 1'b0, a}, 16, rx);
    check(rx[15:8], exp);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    check(wake_pin_enable, 8'h01);
    check(spi_sdo_oe, 8'h00);
    rd_chk(ADDR_INT_WAKE, 8'h00);
    rd_chk(ADDR_EXT_WAKE, 8'h01);
    rd_chk(ADDR_PULL, 8'h00);
    rd_chk(ADDR_SPEED, 8'h00);
    rd_chk(7'h09, 8'h00);
    $display("reset values done");
  endtask

  task automatic t_write_keep;
    wr(ADDR_INT_WAKE, 8'hFF);
    wr(ADDR_EXT_WAKE, 8'hFF);
    wr(ADDR_PULL, 8'hFF);
    wr(ADDR_SPEED, 8'hFF);
    wr(7'h09, 8'hFF);
    wr(7'h04, 8'h01);
    check({timer_wake_enable, wdog_stop_disable_b1}, 8'h03);
    check({wake_pin_sense_sel, wake_pin_enable, fast_mode, wake_pull_sel}, 8'h17);
    rd_chk(ADDR_EXT_WAKE, 8'hA1);
    rd_chk(7'h09, 8'h00);
    pulse(3);
    check({timer_wake_enable, wdog_stop_disable_b1}, 8'h02);
    wr(ADDR_INT_WAKE, 8'h44);
    rd_chk(ADDR_INT_WAKE, 8'h44);
    pulse(1);
    rd_chk(ADDR_INT_WAKE, 8'h40);
    rd_chk(ADDR_EXT_WAKE, 8'hA1);
    rd_chk(ADDR_PULL, 8'hC3);
    rd_chk(ADDR_SPEED, 8'h10);
    $display("write and restart done");
  endtask

  task automatic t_sense;
    mode_normal = 1'b1;
    {wake_pin, general_io_in} = 2'h3;
    tick(3);
    check({meas_enable, gpio_cfg_ignore, wake_pin_level, general_io_level}, 8'h0C);
    fail_output = 1'b1;
    tick(2);
    check(gpio_cfg_ignore, 8'h00);
    fail_output = 1'b0;
    pulse(0);
    rd_chk(ADDR_EXT_WAKE, 8'h01);
    rd_chk(ADDR_SPEED, 8'h00);
    rd_chk(ADDR_INT_WAKE, 8'h00);
    check({meas_enable, wake_pin_level, general_io_level}, 8'h03);
    $display("sensing done");
  endtask

  task automatic t_pull;
    gpio_is_wake = 1'b1;
    for (int c = 0; c < 4; c++)
    begin
      wr(ADDR_PULL, {c[1:0], 4'hF, c[1:0]});
      check({general_io_wake_pull_sel, wake_pull_sel}, {4'h0, c[1:0], c[1:0]});
      rd_chk(ADDR_PULL, {c[1:0], 4'h0, c[1:0]});
    end
    gpio_is_wake = 1'b0;
    tick(2);
    check(general_io_wake_pull_sel, 8'h00);
    $display("pull codes done");
  endtask

  task automatic t_fail;
    logic [15:0] rx;
    wr(ADDR_EXT_WAKE, 8'h80);
    check(wake_pin_enable, 8'h00);
    pulse(2);
    rd_chk(ADDR_EXT_WAKE, 8'h81);
    wr(ADDR_EXT_WAKE, 8'hA0);
    pulse(2);
    rd_chk(ADDR_EXT_WAKE, 8'hA0);
    wr(ADDR_EXT_WAKE, 8'h01);
    fail_output = 1'b1;
    wr(ADDR_EXT_WAKE, 8'h21);
    rd_chk(ADDR_EXT_WAKE, 8'h01);
    check(spi_fail, 8'h01);
    host.xfer({8'h00, 1'b0, ADDR_EXT_WAKE}, 16, rx);
    check(rx[7:0], 8'h80);
    check(rx[15:8], 8'h01);
    fail_output = 1'b0;
    pulse(6);
    wr(ADDR_EXT_WAKE, 8'h80, 15);
    check(spi_fail, 8'h01);
    rd_chk(ADDR_EXT_WAKE, 8'h01);
    pulse(6);
    $display("fail-safe and refusal done");
  endtask

  task automatic t_irq;
    pulse(5);
    check(irq_out_n, 8'h01);
    pulse(4);
    check(irq_out_n, 8'h00);
    wr(ADDR_EXT_WAKE, 8'h81);
    pulse(5);
    check(irq_out_n, 8'h00);
    $display("interrupt scope done");
  endtask

  task automatic print_verdict;
    $display("compares %0d errors %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    sys_rst = 1'b1;
    ev = 7'h00;
    {mode_normal, fail_output, gpio_is_wake, wake_pin, general_io_in} = 5'h00;
    repeat (12) @(posedge ref_clk);
    #1;
    sys_rst = 1'b0;
    tick(1);
    t_reset();
    t_write_keep();
    t_sense();
    t_pull();
    t_fail();
    t_irq();
    print_verdict();
  end

  initial
  begin
    #200000;
    num_errors++;
    print_verdict();
  end
endmodule // wsc_wake_regs_bench
